// [logic/jsc_sync_ctrl.sv]
// SYNC request input control: source select, link start-up, SYSREF alignment
`timescale 1ns/10ps
`include "jsc_defs.svh"
module jsc_sync_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Request and reference pins
  input wire logic single_ended_sync_pin,
  input wire logic timestamp_diff_pair,
  input wire logic sysref_pin,
  // Configuration
  input wire logic sync_source_select,
  input wire logic timestamp_receiver_enable,
  input wire logic link_mode_64b66b,
  input wire logic nco_sync_enable,
  // Link control status
  output jsc_pkg::jsc_link_t link_state,
  output logic cgs_active,
  output logic ilas_start,
  output logic ilas_active,
  output logic data_active,
  output logic sync_request,
  // Timing events
  output logic nco_sync_pulse,
  output logic sysref_pulse,
  output logic lmfc_pulse
);
  import jsc_pkg::*;

  logic se_level;
  logic ts_level;
  logic sr_level;
  logic sel_req;
  logic req_q;
  logic req_fall;
  logic req_rise;
  logic sr_q;
  logic sr_rise;
  logic [4:0] lmfc_cnt;
  logic lmfc_bound;
  logic [1:0] ilas_mf;
  logic ilas_last;
  jsc_link_t state;
  jsc_link_t next_state;

  function automatic logic jsc_req_of(input logic lvl);
    jsc_req_of = ~lvl;
  endfunction

  jsc_sync3 #(.RST_LVL(`JSC_SYNC_IDLE)) u_sync_se (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(single_ended_sync_pin),
    .level_out(se_level)
  );
  jsc_sync3 #(.RST_LVL(`JSC_SYNC_IDLE)) u_sync_ts (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(timestamp_diff_pair),
    .level_out(ts_level)
  );
  jsc_sync3 #(.RST_LVL(`JSC_SYSREF_IDLE)) u_sync_sr (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(sysref_pin),
    .level_out(sr_level)
  );

  // source select, gate the differential pair
  always_comb
  begin
    if (sync_source_select == `JSC_SRC_SINGLE)
      sel_req = jsc_req_of(se_level);
    else if (timestamp_receiver_enable)
      sel_req = jsc_req_of(ts_level);
    else
      sel_req = 1'b0;
  end

  // Previous request and SYSREF levels for edge detection
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      req_q <= 1'b0;
      sr_q <= `JSC_SYSREF_IDLE;
    end
    else
    begin
      req_q <= sel_req;
      sr_q <= sr_level;
    end
  end

  assign req_fall = sel_req & ~req_q;
  assign req_rise = ~sel_req & req_q;
  assign sr_rise = sr_level & ~sr_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      lmfc_cnt <= `JSC_LMFC_RST;
    else if (sr_rise)
      lmfc_cnt <= `JSC_LMFC_RST;
    else if (lmfc_cnt == `JSC_LMFC_LAST)
      lmfc_cnt <= `JSC_LMFC_RST;
    else
      lmfc_cnt <= lmfc_cnt + 5'h01;
  end

  assign lmfc_bound = (lmfc_cnt == `JSC_LMFC_LAST) & ~sr_rise;

  // Multiframes spent in the alignment sequence
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ilas_mf <= `JSC_ILAS_MF_RST;
    else if (state != JSC_ILAS)
      ilas_mf <= `JSC_ILAS_MF_RST;
    else if (lmfc_bound)
      ilas_mf <= ilas_mf + 2'h1;
  end

  assign ilas_last = lmfc_bound & (ilas_mf == `JSC_ILAS_MF_LAST);

  // Link start-up sequencing
  always_comb
  begin
    next_state = state;
    // 64b/66b ignores the request for start-up
    if (link_mode_64b66b)
      next_state = JSC_IDLE;
    else
    begin
      case (state)
        // low request enters code group sync
        JSC_IDLE:
          if (sel_req)
            next_state = JSC_CGS;
        JSC_CGS:
          if (req_rise)
            next_state = JSC_ILAS_WAIT;
        // alignment starts on a multiframe boundary
        JSC_ILAS_WAIT:
          if (sel_req)
            next_state = JSC_CGS;
          else if (lmfc_bound)
            next_state = JSC_ILAS;
        JSC_ILAS:
          if (sel_req)
            next_state = JSC_CGS;
          else if (ilas_last)
            next_state = JSC_DATA;
        JSC_DATA:
          if (sel_req)
            next_state = JSC_CGS;
        default:
          next_state = JSC_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      state <= JSC_IDLE;
    else
      state <= next_state;
  end

  // Registered status outputs
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      link_state <= JSC_IDLE;
      cgs_active <= 1'b0;
      ilas_start <= 1'b0;
      ilas_active <= 1'b0;
      data_active <= 1'b0;
      sync_request <= 1'b0;
    end
    else
    begin
      link_state <= next_state;
      cgs_active <= (next_state == JSC_CGS);
      ilas_start <= (next_state == JSC_ILAS) & (state != JSC_ILAS);
      ilas_active <= (next_state == JSC_ILAS);
      data_active <= (next_state == JSC_DATA);
      sync_request <= sel_req;
    end
  end

  // request edge as NCO sync trigger in 64b/66b
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      nco_sync_pulse <= 1'b0;
    else
      nco_sync_pulse <= link_mode_64b66b & nco_sync_enable & req_fall;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sysref_pulse <= 1'b0;
      lmfc_pulse <= 1'b0;
    end
    else
    begin
      sysref_pulse <= sr_rise;
      lmfc_pulse <= lmfc_bound;
    end
  end

  chk_select_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sync_source_select == 1'b0) |-> (sel_req == ~se_level))
    else $error("single-ended source not selected");

  chk_select_diff: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sync_source_select && timestamp_receiver_enable) |-> (sel_req == ~ts_level))
    else $error("differential source not selected or not active low");

  chk_diff_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sync_source_select && !timestamp_receiver_enable) |-> !sel_req)
    else $error("disabled differential receiver gave a request");

  chk_cgs_on_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!link_mode_64b66b && sel_req) |=> (cgs_active && state == JSC_CGS))
    else $error("low request did not enter code group sync");

  chk_rise_to_ilas: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!link_mode_64b66b && state == JSC_CGS && req_rise) |=> (state == JSC_ILAS_WAIT)
    ##[0:32] (ilas_start || cgs_active))
    else $error("release after CGS did not start alignment in a multiframe");

  chk_restart_cgs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (data_active && !link_mode_64b66b && sel_req) |=> (cgs_active && !data_active))
    else $error("renewed request after alignment did not restart CGS");

  chk_64b_no_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    link_mode_64b66b |=> (state == JSC_IDLE && !cgs_active && !ilas_active))
    else $error("request affected start-up in 64b/66b mode");

  chk_nco_trigger: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (link_mode_64b66b && nco_sync_enable && req_fall) |=> nco_sync_pulse)
    else $error("NCO sync trigger missing");

  chk_sysref_align: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sr_rise |=> (lmfc_cnt == 5'h00) ##31 lmfc_bound || sr_rise)
    else $error("SYSREF did not realign the multiframe counter");

  chk_ilas_on_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(ilas_active) |-> $past(lmfc_bound))
    else $error("alignment started off a multiframe boundary");
endmodule

// [logic/jsc_defs.svh]
// Constants for the SYNC request input control block
`ifndef JSC_DEFS_SVH
`define JSC_DEFS_SVH
// Idle level of the active-low SYNC request inputs after reset
`define JSC_SYNC_IDLE 1'b1
// Idle level of the SYSREF input after reset
`define JSC_SYSREF_IDLE 1'b0
// Last count of the local multiframe counter (32 cycles a multiframe)
`define JSC_LMFC_LAST 5'h1F
// Reset value of the local multiframe counter
`define JSC_LMFC_RST 5'h00
// Last multiframe of the alignment sequence (4 multiframes)
`define JSC_ILAS_MF_LAST 2'h3
// Reset value of the alignment multiframe counter
`define JSC_ILAS_MF_RST 2'h0
// Sync source select encodings
`define JSC_SRC_SINGLE 1'b0
`define JSC_SRC_DIFF 1'b1
`endif

// [logic/jsc_pkg.sv]
// Types for the SYNC request input control block
package jsc_pkg;
  // Link start-up states
  typedef enum logic [2:0] {
    JSC_IDLE,
    JSC_CGS,
    JSC_ILAS_WAIT,
    JSC_ILAS,
    JSC_DATA
  } jsc_link_t;
endpackage

// [logic/jsc_sync3.sv]
// Three-stage pin synchronizer with agreement filter
`timescale 1ns/10ps
`include "jsc_defs.svh"
module jsc_sync3 #(
  parameter logic RST_LVL = `JSC_SYNC_IDLE
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Asynchronous pin level
  input wire logic pin_in,
  // Filtered level in the clock domain
  output logic level_out
);
  import jsc_pkg::*;
  logic ff1;
  logic ff2;
  logic ff3;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ff1 <= RST_LVL;
      ff2 <= RST_LVL;
      ff3 <= RST_LVL;
    end
    else
    begin
      ff1 <= pin_in;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      level_out <= RST_LVL;
    else if (ff2 == ff3)
      level_out <= ff3;
  end

  chk_sync_agree_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (level_out != $past(level_out)) |-> ($past(ff2) == $past(ff3)))
    else $error("synchronizer output moved without stage agreement");
endmodule

// [bench/jsc_rx_model.sv]
// Receiver-side model that drives the SYNC request pins
`timescale 1ns/10ps
module jsc_rx_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Request control from the bench
  input wire logic req,
  input wire logic use_diff,
  // Driven request pins
  output logic single_ended_sync_pin,
  output logic timestamp_diff_pair
);
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      single_ended_sync_pin <= 1'b1;
      timestamp_diff_pair <= 1'b1;
    end
    else
    begin
      // Unused single-ended pin is tied low
      single_ended_sync_pin <= use_diff ? 1'b0 : !req;
      timestamp_diff_pair <= use_diff ? !req : 1'b1;
    end
  end
endmodule

// [bench/test_jsc_sync_ctrl.sv]
// Testbench for the SYNC request input control block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module test_jsc_sync_ctrl;
  import jsc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sysref_pin = 1'b0;
  logic sync_source_select = 1'b0;
  logic timestamp_receiver_enable = 1'b1;
  logic link_mode_64b66b = 1'b0;
  logic nco_sync_enable = 1'b0;
  logic req = 1'b0;
  logic use_diff = 1'b0;
  wire logic single_ended_sync_pin;
  wire logic timestamp_diff_pair;
  jsc_link_t link_state;
  logic cgs_active, ilas_start, ilas_active, data_active, sync_request;
  logic nco_sync_pulse, sysref_pulse, lmfc_pulse;
  int bad_count = 0;
  int samples_checked = 0;
  int n;
  jsc_rx_model jsc_rx_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .req(req),
    .use_diff(use_diff), .single_ended_sync_pin(single_ended_sync_pin),
    .timestamp_diff_pair(timestamp_diff_pair));
  jsc_sync_ctrl jsc_sync_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .single_ended_sync_pin(single_ended_sync_pin), .timestamp_diff_pair(timestamp_diff_pair),
    .sysref_pin(sysref_pin), .sync_source_select(sync_source_select),
    .timestamp_receiver_enable(timestamp_receiver_enable),
    .link_mode_64b66b(link_mode_64b66b), .nco_sync_enable(nco_sync_enable),
    .link_state(link_state), .cgs_active(cgs_active), .ilas_start(ilas_start),
    .ilas_active(ilas_active), .data_active(data_active), .sync_request(sync_request),
    .nco_sync_pulse(nco_sync_pulse), .sysref_pulse(sysref_pulse), .lmfc_pulse(lmfc_pulse));
  // Clock at 8 ns
  initial
  begin
    forever #4 sys_clk = !sys_clk;
  end
  // Wait up to 300 cycles for a chosen output, cycles in n or -1
  task automatic wait_for(input int which, output int n);
    logic s;
    begin
      n = -1;
      for (int i = 1; i <= 300 && n < 0; i++)
      begin
        @(posedge sys_clk);
        #1;
        case (which)
          0: s = cgs_active;
          1: s = ilas_start;
          2: s = data_active;
          3: s = nco_sync_pulse;
          4: s = sysref_pulse;
          default: s = lmfc_pulse;
        endcase
        if (s === 1'b1)
          n = i;
      end
    end
  endtask
  // Full start-up from request to data
  task automatic t_start;
    begin
      @(posedge sys_clk) req <= 1'b1;
      wait_for(0, n);
      `CHK("cgs", 1'b1, n >= 0)
      `CHK("state", JSC_CGS, link_state)
      `CHK("req_seen", 1'b1, sync_request)
      @(posedge sys_clk) req <= 1'b0;
      wait_for(1, n);
      `CHK("ilas_start", 1'b1, n >= 0)
      `CHK("ilas", 1'b1, ilas_active)
      wait_for(2, n);
      `CHK("data", 1'b1, data_active)
      $display("test start done");
    end
  endtask
  // Request again while in data
  task automatic t_restart;
    begin
      @(posedge sys_clk) req <= 1'b1;
      wait_for(0, n);
      `CHK("recgs", 1'b1, n >= 0)
      `CHK("data_off", 1'b0, data_active)
      @(posedge sys_clk) req <= 1'b0;
      wait_for(2, n);
      `CHK("redata", 1'b1, data_active)
      $display("test restart done");
    end
  endtask
  // Differential source, single-ended tied low
  task automatic t_diff;
    begin
      @(posedge sys_clk) use_diff <= 1'b1;
      sync_source_select <= 1'b1;
      repeat (12) @(posedge sys_clk);
      #1;
      `CHK("no_req", 1'b0, sync_request)
      t_start();
      @(posedge sys_clk) req <= 1'b1;
      wait_for(0, n);
      @(posedge sys_clk) timestamp_receiver_enable <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("rx_off", 1'b0, sync_request)
      @(posedge sys_clk) req <= 1'b0;
      timestamp_receiver_enable <= 1'b1;
      use_diff <= 1'b0;
      wait_for(2, n);
      `CHK("diff_data", 1'b1, data_active)
      @(posedge sys_clk) sync_source_select <= 1'b0;
      repeat (8) @(posedge sys_clk);
      $display("test diff done");
    end
  endtask
  // 64b/66b request gives NCO sync only
  task automatic t_wide;
    begin
      @(posedge sys_clk) link_mode_64b66b <= 1'b1;
      nco_sync_enable <= 1'b1;
      repeat (4) @(posedge sys_clk);
      req <= 1'b1;
      wait_for(3, n);
      `CHK("nco", 1'b1, n >= 0)
      `CHK("idle", JSC_IDLE, link_state)
      `CHK("cgs_off", 1'b0, cgs_active)
      @(posedge sys_clk) req <= 1'b0;
      repeat (8) @(posedge sys_clk);
      link_mode_64b66b <= 1'b0;
      $display("test wide done");
    end
  endtask
  // SYSREF rise restarts multiframe timing
  task automatic t_sysref;
    begin
      @(posedge sys_clk) sysref_pin <= 1'b1;
      wait_for(4, n);
      `CHK("sysref", 1'b1, n >= 0)
      wait_for(5, n);
      `CHK("lmfc_gap", 32, n)
      @(posedge sys_clk) sysref_pin <= 1'b0;
      $display("test sysref done");
    end
  endtask
  // Counts and verdict
  task automatic results;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Hang guard
  initial
  begin
    #(20000 * 8);
    bad_count++;
    results();
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_sysref();
    t_start();
    t_restart();
    t_diff();
    t_wide();
    results();
  end
endmodule
